// >>> lx_pkg.sv
// Function
// - On transmit a content octet 7E is sent as the pair 7D, 5E.
// - On transmit a content octet 7D is sent as the pair 7D, 5D.
// - On receive a rate-adaptation pair 7D, DD is deleted and adds nothing to the frame.
// - On receive the pair 7D, 5E becomes one 7E octet.
// - On receive the pair 7D, 5D becomes one 7D octet.
// - On receive the abort sequence 7D, 7E ends the packet being assembled with abort status; octets already passed on stay delivered.
// - Address and control values are held for each direction, inserted on transmit and checked on receive.
// - A two-octet SAPI value is held for each direction, inserted on transmit and checked on receive.
// - Payload is scrambled on transmit and descrambled on receive with a self-synchronizing x^43 + 1 scrambler.
// - Each received frame reports bad header, FCS error, abort or excess length.
// - A byte-boundary mark is active during the last serial bit of each transmitted octet.
`default_nettype none
package lx_pkg;
   localparam logic [7:0]  LX_FLAG      = 8'h7E;
   localparam logic [7:0]  LX_ESC       = 8'h7D;
   localparam logic [7:0]  LX_ESC_FLAG  = 8'h5E;
   localparam logic [7:0]  LX_ESC_ESC   = 8'h5D;
   localparam logic [7:0]  LX_RATE_FILL = 8'hDD;
   localparam logic [7:0]  LX_ESC_XOR   = 8'h20;
   localparam logic [31:0] LX_CRC_INIT  = 32'hFFFFFFFF;
   localparam logic [31:0] LX_CRC_POLY  = 32'hEDB88320;
   localparam logic [31:0] LX_CRC_RESID = 32'hDEBB20E3;
   localparam logic [11:0] LX_HDR_LEN   = 12'h004;
   localparam logic [11:0] LX_OVH_LEN   = 12'h008;
   localparam logic [11:0] LX_IDX_MAX   = 12'hFFF;
   localparam logic [2:0]  LX_LAST_BIT  = 3'h7;
   localparam int          LX_SCR_LEN   = 43;
   localparam int          LX_FIFO_W    = 9;
   localparam int          LX_FIFO_D    = 32;

   // Static configuration, both directions
   typedef struct packed {
      logic [7:0]  tx_addr;
      logic [7:0]  tx_ctrl;
      logic [15:0] tx_sapi;
      logic [7:0]  rx_addr;
      logic [7:0]  rx_ctrl;
      logic [15:0] rx_sapi;
      logic [10:0] max_len;
   } lx_cfg_t;

   typedef struct packed {
      logic hdr_err;
      logic fcs_err;
      logic abort;
      logic too_long;
   } lx_rxst_t;

   typedef struct packed {
      logic       fin;
      logic [7:0] data;
      lx_rxst_t   st;
   } lx_rxw_t;

   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } lx_txw_t;

   // Reflected CRC-32, one octet, LSB first
   function automatic logic [31:0] lx_crc8(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ LX_CRC_POLY) : (r >> 1);
      return r;
   endfunction

   // x^43+1 scrambler; returns {state, octet}; rx selects descrambling
   function automatic logic [50:0] lx_scr(input logic [42:0] s, input logic [7:0] d, input logic rx);
      logic [42:0] r;
      logic [7:0]  o;
      r = s;
      o = '0;
      for (int i = 0; i < 8; i++)
      begin
         o[i] = d[i] ^ r[LX_SCR_LEN-1];
         r    = {r[LX_SCR_LEN-2:0], (rx ? d[i] : o[i])};
      end
      return {r, o};
   endfunction
endpackage : lx_pkg
`default_nettype wire

// >>> lx_fifo.sv
`default_nettype none
module lx_fifo import lx_pkg::*;
#(
   parameter int W = LX_FIFO_W,
   parameter int D = LX_FIFO_D
)
(
   input  wire logic         clk_sys,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output var  logic         in_ready,
   output var  logic [W-1:0] out_data,
   output var  logic         out_valid,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(D);

   logic [W-1:0]  mem_ff [D];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0]   cnt_ff;
   logic [AW:0]   nxt_cnt;
   logic          push;
   logic          pop;

   // Handshakes and next fill level
   assign push     = in_valid & in_ready;
   assign pop      = out_valid & out_ready;
   assign nxt_cnt  = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
   assign out_data = mem_ff[rd_ptr_ff];

   // Storage, no reset needed
   always_ff @(posedge clk_sys)
   begin
      if (push)
         mem_ff[wr_ptr_ff] <= in_data;
   end

   // Pointers and registered flags
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff    <= '0;
         in_ready  <= 1'h0;
         out_valid <= 1'h0;
      end
      else
      begin
         wr_ptr_ff <= wr_ptr_ff + AW'(push);
         rd_ptr_ff <= rd_ptr_ff + AW'(pop);
         cnt_ff    <= nxt_cnt;
         in_ready  <= nxt_cnt != (AW+1)'(D);   // Honest full
         out_valid <= nxt_cnt != '0;           // Honest empty
      end
   end
endmodule // lx_fifo
`default_nettype wire

// >>> lx_framer.sv
`default_nettype none
module lx_framer import lx_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       tx_clk,
   input  wire logic       rx_clk,
   input  wire lx_cfg_t    cfg,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_last,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   output var  logic       tx_serial_out,
   output var  logic       tx_byte_boundary_mark,
   input  wire logic       rx_serial_in,
   output var  logic       rx_valid,
   output var  logic [7:0] rx_data,
   output var  logic       rx_end,
   output var  lx_rxst_t   rx_status
);
   typedef enum {LX_IDLE, LX_HDR, LX_PAY, LX_FCS} lx_txfsm_t;

   lx_txw_t    f_data, hold_ff, stage_ff;
   logic       f_valid, pend_ff, ack_tog_ff, tq1_ff, tq2_ff, tq3_ff;
   logic       trs1_ff, trs_b_ff, req_tog_ff, wait_ff, full_ff, a1_ff, a2_ff, a3_ff;
   lx_cfg_t    tcf1_ff, tcf_ff, rcf1_ff, rcf_ff;
   lx_txfsm_t  st_ff, nxt_st;
   logic [1:0] idx_ff, nxt_idx;
   logic [31:0] crc_ff, nxt_crc, hdr_w;
   logic [42:0] scr_ff, nxt_scr;
   logic [50:0] s51;
   logic [7:0] poct_ff, nxt_poct, oct, raw, c, sh_ff, cur_oct_ff;
   logic       pend_o_ff, nxt_pend, take, cont, scr_use, load;
   logic [2:0] cnt_ff;

   // Transmit words enter the FIFO in the system domain
   lx_fifo #(.W(LX_FIFO_W), .D(LX_FIFO_D)) u_fifo (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .in_data   ({tx_last, tx_data}),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (pend_ff)
   );

   // Request toggle from link side, answered with one FIFO word
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         {tq1_ff, tq2_ff, tq3_ff, pend_ff, ack_tog_ff} <= '0;
         hold_ff <= '0;
      end
      else
      begin
         {tq1_ff, tq2_ff, tq3_ff} <= {req_tog_ff, tq1_ff, tq2_ff};
         if (tq2_ff ^ tq3_ff)
            pend_ff <= 1'h1;
         else if (f_valid)
            pend_ff <= 1'h0;
         if (pend_ff && f_valid)
         begin
            hold_ff    <= f_data;    // Stable until next request
            ack_tog_ff <= ~ack_tog_ff;
         end
      end
   end

   // Link-side reset release and config synchronisers
   always_ff @(posedge tx_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         {trs1_ff, trs_b_ff} <= '0;
         {tcf1_ff, tcf_ff}   <= '0;
      end
      else
      begin
         {trs1_ff, trs_b_ff} <= {1'h1, trs1_ff};
         {tcf1_ff, tcf_ff}   <= {cfg, tcf1_ff};
      end
   end

   // One-word stage filled by the request/acknowledge toggles
   always_ff @(posedge tx_clk or negedge trs_b_ff)
   begin
      if (!trs_b_ff)
      begin
         {a1_ff, a2_ff, a3_ff, req_tog_ff, wait_ff, full_ff} <= '0;
         stage_ff <= '0;
      end
      else
      begin
         {a1_ff, a2_ff, a3_ff} <= {ack_tog_ff, a1_ff, a2_ff};
         if (a2_ff ^ a3_ff)
         begin
            full_ff  <= 1'h1;
            wait_ff  <= 1'h0;
            stage_ff <= hold_ff;
         end
         else
         begin
            if (load && take)
               full_ff <= 1'h0;
            if (!full_ff && !wait_ff)
            begin
               req_tog_ff <= ~req_tog_ff;
               wait_ff    <= 1'h1;
            end
         end
      end
   end

   // Next octet choice at each byte boundary
   assign load  = cnt_ff == LX_LAST_BIT;
   assign hdr_w = {tcf_ff.tx_addr, tcf_ff.tx_ctrl, tcf_ff.tx_sapi};
   always_comb
   begin
      nxt_st   = st_ff;
      nxt_idx  = idx_ff;
      nxt_crc  = crc_ff;
      nxt_scr  = scr_ff;
      nxt_pend = 1'h0;
      nxt_poct = poct_ff;
      oct      = LX_FLAG;
      raw      = LX_FLAG;
      c        = LX_FLAG;
      take     = 1'h0;
      cont     = 1'h0;
      scr_use  = 1'h0;
      s51      = '0;
      if (pend_o_ff)
         oct = poct_ff;                                         // Second octet of a pair
      else
      begin
         unique case (st_ff)
            LX_IDLE:
               if (full_ff)
               begin
                  nxt_st  = LX_HDR;                             // Opening flag goes out now
                  nxt_idx = '0;
                  nxt_crc = LX_CRC_INIT;
               end
            LX_HDR:
            begin
               raw     = hdr_w[{2'h3 - idx_ff, 3'h0} +: 8];     // Address, control, SAPI
               cont    = 1'h1;
               nxt_crc = lx_crc8(crc_ff, raw);
               nxt_idx = idx_ff + 2'h1;
               if (idx_ff == 2'h3)
                  nxt_st = LX_PAY;
            end
            LX_PAY:
               if (full_ff)
               begin
                  raw     = stage_ff.data;
                  cont    = 1'h1;
                  scr_use = 1'h1;
                  take    = 1'h1;
                  nxt_crc = lx_crc8(crc_ff, raw);
                  if (stage_ff.last)
                  begin
                     nxt_st  = LX_FCS;
                     nxt_idx = '0;
                  end
               end
               else
               begin
                  oct      = LX_ESC;                           // Rate-adaptation fill pair
                  nxt_pend = 1'h1;
                  nxt_poct = LX_RATE_FILL;
               end
            LX_FCS:
            begin
               raw     = ~crc_ff[{idx_ff, 3'h0} +: 8];         // FCS, low octet first
               cont    = 1'h1;
               scr_use = 1'h1;
               nxt_idx = idx_ff + 2'h1;
               if (idx_ff == 2'h3)
                  nxt_st = LX_IDLE;                            // Closing flag follows
            end
         endcase
         if (cont)
         begin
            s51 = lx_scr(scr_ff, raw, 1'h0);
            c   = scr_use ? s51[7:0] : raw;                    // Scramble payload and FCS
            if (scr_use)
               nxt_scr = s51[50:8];
            if (c == LX_FLAG || c == LX_ESC)
            begin
               oct      = LX_ESC;                              // Transparency
               nxt_pend = 1'h1;
               nxt_poct = c ^ LX_ESC_XOR;
            end
            else
               oct = c;
         end
      end
   end

   // Frame state, advanced once per octet
   always_ff @(posedge tx_clk or negedge trs_b_ff)
   begin
      if (!trs_b_ff)
      begin
         st_ff     <= LX_IDLE;
         idx_ff    <= '0;
         crc_ff    <= LX_CRC_INIT;
         scr_ff    <= '0;
         pend_o_ff <= 1'h0;
         poct_ff   <= '0;
      end
      else if (load)
      begin
         st_ff     <= nxt_st;
         idx_ff    <= nxt_idx;
         crc_ff    <= nxt_crc;
         scr_ff    <= nxt_scr;
         pend_o_ff <= nxt_pend;
         poct_ff   <= nxt_poct;
      end
   end

   // Serialiser, LSB first, with byte mark on the last bit
   always_ff @(posedge tx_clk or negedge trs_b_ff)
   begin
      if (!trs_b_ff)
      begin
         cnt_ff                <= LX_LAST_BIT;
         sh_ff                 <= LX_FLAG;
         cur_oct_ff            <= LX_FLAG;
         tx_serial_out         <= 1'h0;
         tx_byte_boundary_mark <= 1'h0;
      end
      else
      begin
         cnt_ff                <= cnt_ff + 3'h1;
         tx_byte_boundary_mark <= cnt_ff == 3'h6;
         if (load)
         begin
            cur_oct_ff    <= oct;
            tx_serial_out <= oct[0];
            sh_ff         <= oct >> 1;
         end
         else
         begin
            tx_serial_out <= sh_ff[0];
            sh_ff         <= sh_ff >> 1;
         end
      end
   end

   chk_tx_flag_esc: assert property (@(posedge tx_clk) disable iff (!trs_b_ff)
      load && cont && c == LX_FLAG |=> cur_oct_ff == LX_ESC ##8 cur_oct_ff == LX_ESC_FLAG)
      else $error("flag octet not escaped as 7D 5E");
   chk_tx_esc_esc: assert property (@(posedge tx_clk) disable iff (!trs_b_ff)
      load && cont && c == LX_ESC |=> cur_oct_ff == LX_ESC ##8 cur_oct_ff == LX_ESC_ESC)
      else $error("escape octet not escaped as 7D 5D");
   chk_mark_period: assert property (@(posedge tx_clk) disable iff (!trs_b_ff)
      tx_byte_boundary_mark |=> !tx_byte_boundary_mark [*7] ##1 tx_byte_boundary_mark)
      else $error("byte mark not once every eight bits");
   chk_idle_flag: assert property (@(posedge tx_clk) disable iff (!trs_b_ff)
      load && !pend_o_ff && st_ff == LX_IDLE |=> cur_oct_ff == LX_FLAG)
      else $error("idle octet is not a flag");
   cov_tx_fill: cover property (@(posedge tx_clk) disable iff (!trs_b_ff)
      load && st_ff == LX_PAY && !full_ff);

   logic       rrs1_ff, rrs_b_ff, rs1_ff, rs2_ff, sync_ff, esc_ff, emit_ff, rtog_ff;
   logic [7:0] sr_ff, nsr, eb_ff, db, hexp;
   logic [2:0] bc_ff;
   logic       flag_ev, oct_ev;
   logic [11:0] ridx_ff;
   logic [31:0] rcrc_ff, dly_ff, rhdr_w;
   logic [42:0] dscr_ff;
   logic [50:0] d51;
   logic       herr_ff, r1_ff, r2_ff, r3_ff;
   lx_rxw_t    xw_ff;
   lx_rxst_t   est;

   // Receive reset release, config and pin synchronisers
   always_ff @(posedge rx_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         {rrs1_ff, rrs_b_ff, rs1_ff, rs2_ff} <= '0;
         {rcf1_ff, rcf_ff} <= '0;
      end
      else
      begin
         {rrs1_ff, rrs_b_ff} <= {1'h1, rrs1_ff};
         {rs1_ff, rs2_ff}    <= {rx_serial_in, rs1_ff};
         {rcf1_ff, rcf_ff}   <= {cfg, rcf1_ff};
      end
   end

   // Flag hunt and octet alignment
   assign nsr     = {rs2_ff, sr_ff[7:1]};
   assign flag_ev = nsr == LX_FLAG && (!sync_ff || bc_ff == LX_LAST_BIT); // Octet-aligned once locked
   assign oct_ev  = !flag_ev && sync_ff && bc_ff == LX_LAST_BIT;
   always_ff @(posedge rx_clk or negedge rrs_b_ff)
   begin
      if (!rrs_b_ff)
      begin
         sr_ff   <= '0;
         bc_ff   <= '0;
         sync_ff <= 1'h0;
      end
      else
      begin
         sr_ff <= nsr;
         bc_ff <= flag_ev ? 3'h0 : bc_ff + 3'h1;
         if (flag_ev)
            sync_ff <= 1'h1;
      end
   end

   // Transparency removal and fill deletion
   always_ff @(posedge rx_clk or negedge rrs_b_ff)
   begin
      if (!rrs_b_ff)
      begin
         esc_ff  <= 1'h0;
         emit_ff <= 1'h0;
         eb_ff   <= '0;
      end
      else
      begin
         emit_ff <= 1'h0;
         if (flag_ev)
            esc_ff <= 1'h0;
         else if (oct_ev && esc_ff)
         begin
            esc_ff  <= 1'h0;
            emit_ff <= nsr != LX_RATE_FILL;
            eb_ff   <= nsr ^ LX_ESC_XOR;                       // 5E to 7E, 5D to 7D
         end
         else if (oct_ev && nsr == LX_ESC)
            esc_ff <= 1'h1;
         else if (oct_ev)
         begin
            emit_ff <= 1'h1;
            eb_ff   <= nsr;
         end
      end
   end

   // Header check, descrambling, FCS and four-octet FCS hold-back
   assign rhdr_w = {rcf_ff.rx_addr, rcf_ff.rx_ctrl, rcf_ff.rx_sapi};
   assign hexp   = rhdr_w[{2'h3 - ridx_ff[1:0], 3'h0} +: 8];
   assign d51    = lx_scr(dscr_ff, eb_ff, 1'h1);
   assign db     = (ridx_ff >= LX_HDR_LEN) ? d51[7:0] : eb_ff;
   always_ff @(posedge rx_clk or negedge rrs_b_ff)
   begin
      if (!rrs_b_ff)
      begin
         ridx_ff <= '0;
         rcrc_ff <= LX_CRC_INIT;
         herr_ff <= 1'h0;
         dscr_ff <= '0;
         dly_ff  <= '0;
      end
      else if (flag_ev)
      begin
         ridx_ff <= '0;
         rcrc_ff <= LX_CRC_INIT;
         herr_ff <= 1'h0;
      end
      else if (emit_ff)
      begin
         ridx_ff <= (ridx_ff == LX_IDX_MAX) ? ridx_ff : ridx_ff + 12'h001;
         rcrc_ff <= lx_crc8(rcrc_ff, db);
         if (ridx_ff < LX_HDR_LEN && eb_ff != hexp)
            herr_ff <= 1'h1;
         if (ridx_ff >= LX_HDR_LEN)
         begin
            dscr_ff <= d51[50:8];
            dly_ff  <= {db, dly_ff[31:8]};
         end
      end
   end

   // Frame-end status
   always_comb
   begin
      est.hdr_err  = herr_ff || ridx_ff < LX_HDR_LEN;
      est.fcs_err  = rcrc_ff != LX_CRC_RESID || ridx_ff < LX_OVH_LEN;
      est.abort    = esc_ff;
      est.too_long = ridx_ff > {1'h0, rcf_ff.max_len} + LX_OVH_LEN;
   end

   // Words toward the system domain, one toggle each
   always_ff @(posedge rx_clk or negedge rrs_b_ff)
   begin
      if (!rrs_b_ff)
      begin
         xw_ff   <= '0;
         rtog_ff <= 1'h0;
      end
      else if (flag_ev && (ridx_ff != '0 || esc_ff))
      begin
         xw_ff   <= '{fin: 1'h1, data: 8'h00, st: est};
         rtog_ff <= ~rtog_ff;
      end
      else if (emit_ff && ridx_ff >= LX_OVH_LEN)
      begin
         xw_ff   <= '{fin: 1'h0, data: dly_ff[7:0], st: '0};
         rtog_ff <= ~rtog_ff;
      end
   end

   chk_rx_fill_drop: assert property (@(posedge rx_clk) disable iff (!rrs_b_ff)
      oct_ev && esc_ff && nsr == LX_RATE_FILL |=> !emit_ff)
      else $error("fill pair reached frame content");
   chk_rx_unesc_flag: assert property (@(posedge rx_clk) disable iff (!rrs_b_ff)
      oct_ev && esc_ff && nsr == LX_ESC_FLAG |=> emit_ff && eb_ff == LX_FLAG)
      else $error("7D 5E not restored to 7E");
   chk_rx_unesc_esc: assert property (@(posedge rx_clk) disable iff (!rrs_b_ff)
      oct_ev && esc_ff && nsr == LX_ESC_ESC |=> emit_ff && eb_ff == LX_ESC)
      else $error("7D 5D not restored to 7D");
   chk_rx_abort_end: assert property (@(posedge rx_clk) disable iff (!rrs_b_ff)
      flag_ev && esc_ff |=> xw_ff.fin && xw_ff.st.abort && $changed(rtog_ff))
      else $error("abort not reported at frame end");
   chk_rx_hdr_err: assert property (@(posedge rx_clk) disable iff (!rrs_b_ff)
      emit_ff && !flag_ev && ridx_ff < LX_HDR_LEN && eb_ff != hexp |=> herr_ff)
      else $error("header mismatch not flagged");
   chk_rx_fcs_err: assert property (@(posedge rx_clk) disable iff (!rrs_b_ff)
      flag_ev && !esc_ff && ridx_ff >= LX_OVH_LEN && rcrc_ff != LX_CRC_RESID |=> xw_ff.fin && xw_ff.st.fcs_err)
      else $error("bad FCS not flagged");
   chk_rx_dscr_shift: assert property (@(posedge rx_clk) disable iff (!rrs_b_ff)
      emit_ff && !flag_ev && ridx_ff >= LX_HDR_LEN |=> dscr_ff[0] == $past(eb_ff[7]))
      else $error("descrambler state not fed by line bits");
   cov_rx_good: cover property (@(posedge rx_clk) disable iff (!rrs_b_ff)
      flag_ev && ridx_ff > LX_OVH_LEN && rcrc_ff == LX_CRC_RESID && !herr_ff);
   cov_rx_abort: cover property (@(posedge rx_clk) disable iff (!rrs_b_ff) flag_ev && esc_ff);

   // System-side receive outputs
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         {r1_ff, r2_ff, r3_ff, rx_valid, rx_end} <= '0;
         rx_data   <= '0;
         rx_status <= '0;
      end
      else
      begin
         {r1_ff, r2_ff, r3_ff} <= {rtog_ff, r1_ff, r2_ff};
         rx_valid <= (r2_ff ^ r3_ff) && !xw_ff.fin;
         rx_end   <= (r2_ff ^ r3_ff) && xw_ff.fin;
         if (r2_ff ^ r3_ff)
         begin
            rx_data   <= xw_ff.data;
            rx_status <= xw_ff.st;
         end
      end
   end
endmodule // lx_framer
`default_nettype wire

// >>> lx_far.sv
`default_nettype none
module lx_far
(
   input  wire logic tx_clk,
   input  wire logic rx_clk,
   input  wire logic tx_serial_out,
   input  wire logic tx_byte_boundary_mark,
   input  wire logic loop_en,
   output var  logic rx_serial_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cap_sr  = 8'h00;
   logic [7:0] out_sr  = 8'h7E;
   int         bit_cnt = 0;
   logic [7:0] rxq[$];
   logic [7:0] capq[$];

   // Queue an octet for the receive line
   task automatic push(input logic [7:0] b);
      rxq.push_back(b);
   endtask

   // Capture line octets LSB first, closed by the mark
   always @(negedge tx_clk)
   begin
      cap_sr = {tx_serial_out, cap_sr[7:1]};
      if (tx_byte_boundary_mark === 1'b1)
      begin
         capq.push_back(cap_sr);
         if (loop_en)
            rxq.push_back(cap_sr);
      end
   end

   // Feed line; two octets of slack in loop mode ride out a capture race
   always @(negedge rx_clk)
   begin
      if (bit_cnt == 0)
         out_sr = (rxq.size() > (loop_en ? 2 : 0)) ? rxq.pop_front() : 8'h7E;
      rx_serial_in <= out_sr[bit_cnt];
      bit_cnt = (bit_cnt + 1) % 8;
   end
endmodule // lx_far
`default_nettype wire

// >>> tb_laps_x86_encapsulation.sv
`default_nettype none
module tb_laps_x86_encapsulation import lx_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk_sys  = 1'b0;
   logic       lnk_clk  = 1'b0;
   logic       rst_b    = 1'b0;
   logic       loop_en  = 1'b1;
   lx_cfg_t    cfg      = '{8'h03, 8'h05, 16'h1234, 8'h03, 8'h05, 16'h1234, 11'h7FF};
   logic [7:0] tx_data  = 8'h00;
   logic       tx_last  = 1'b0;
   logic       tx_valid = 1'b0;
   logic       tx_ready, tx_serial_out, mark, rx_serial_in, rx_valid, rx_end;
   logic [7:0] rx_data;
   lx_rxst_t   rx_status, end_st;
   logic [7:0] gotq[$];
   int         error_cnt = 0, total_checks = 0, end_cnt = 0, cyc = 0, ends0;
   logic       saw_full = 1'b0;
   // Rows: octet sent, octet expected back
   logic [15:0] rows [8] = '{16'h1111, 16'h7E7E, 16'h7D7D, 16'h5E5E, 16'h5D5D, 16'hDDDD, 16'h0000, 16'hFFFF};

   always #20 clk_sys = ~clk_sys;
   // Link clock, offset so its edges never meet those of clk_sys
   initial
   begin
      #13;
      forever #80 lnk_clk = ~lnk_clk;
   end

   lx_framer i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .tx_clk(lnk_clk), .rx_clk(lnk_clk), .cfg(cfg),
      .tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_serial_out(tx_serial_out), .tx_byte_boundary_mark(mark), .rx_serial_in(rx_serial_in),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end), .rx_status(rx_status));
   lx_far i_far (.tx_clk(lnk_clk), .rx_clk(lnk_clk), .tx_serial_out(tx_serial_out),
      .tx_byte_boundary_mark(mark), .loop_en(loop_en), .rx_serial_in(rx_serial_in));

   task automatic complete_run;
      if (error_cnt == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_st(input lx_rxst_t got, input lx_rxst_t exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t status %h exp %h", $time, got, exp);
      end
   endtask

   // Collect receive side, cut a hang short
   always @(posedge clk_sys)
   begin
      if (rx_valid === 1'b1)
         gotq.push_back(rx_data);
      if (rx_end === 1'b1)
      begin
         end_st = rx_status;
         end_cnt++;
      end
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         complete_run();
      end
   end

   // Offer a frame of n octets, holding each until taken
   task automatic send(input int n);
      for (int i = 0; i < n; i++)
      begin
         tx_data  <= rows[i%8][15:8];
         tx_last  <= (i == n - 1);
         tx_valid <= 1'b1;
         do
         begin
            @(posedge clk_sys);
            if (tx_ready === 1'b0)
               saw_full = 1'b1;
         end
         while (tx_ready !== 1'b1);
      end
      tx_valid <= 1'b0;
   endtask

   task automatic wait_end(input int n);
      int k;
      k = 0;
      while (end_cnt < n && k < 4000)
      begin
         @(posedge clk_sys);
         k++;
      end
      chk8(8'(end_cnt), 8'(n));
   endtask

   // Loop a frame round the line and check what comes back
   task automatic run(input int n, input logic [3:0] st);
      ends0 = end_cnt;
      gotq.delete();
      send(n);
      wait_end(ends0 + 1);
      chk_st(end_st, lx_rxst_t'(st));
      if (st == 4'h0)
      begin
         chk8(8'(gotq.size()), 8'(n));
         for (int i = 0; i < n; i++)
            chk8(gotq[i], rows[i%8][7:0]);
      end
   endtask

   initial
   begin
      repeat (4) @(posedge lnk_clk);
      @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (40) @(posedge lnk_clk);
      for (int i = 0; i < 3; i++)
         chk8(i_far.capq[i], 8'h7E);
      @(posedge clk_sys);
      run(40, 4'h0);
      chk8(8'(saw_full), 8'h01);
      cfg.max_len <= 11'h003;
      run(4, 4'h1);
      cfg.max_len <= 11'h7FF;
      cfg.rx_sapi <= 16'h4321;
      run(4, 4'h8);
      cfg.rx_sapi <= 16'h1234;
      cfg.rx_ctrl <= 8'h06;
      run(4, 4'h8);
      loop_en <= 1'b0;
      repeat (160) @(posedge lnk_clk);
      ends0 = end_cnt;
      foreach (rows[i])
         if (i < 4)
            i_far.push(i[0] ? 8'hDD : 8'h7D);
      i_far.push(8'h7E);
      repeat (80) @(posedge lnk_clk);
      chk8(8'(end_cnt), 8'(ends0));
      // Matching header with a wrong FCS, then a short aborted frame
      for (int i = 0; i < 8; i++)
         i_far.push(i < 4 ? 8'(32'h03061234 >> (24 - 8 * i)) : 8'h00);
      i_far.push(8'h7E);
      wait_end(ends0 + 1);
      chk_st(end_st, lx_rxst_t'(4'h4));
      i_far.push(8'h01);
      i_far.push(8'h7D);
      i_far.push(8'h7E);
      wait_end(ends0 + 2);
      chk_st(end_st, lx_rxst_t'(4'hE));
      complete_run();
   end
endmodule // tb_laps_x86_encapsulation
`default_nettype wire
